// ===== rtl/stif_pkg.sv
// Purpose: Shared constants and types for the sensor threshold interrupt filter.
// Assumes: Registers are reached through a simple byte-wide register port of the device.
// Notes:   Offsets are the register addresses of the device's own map.
package stif_pkg;
	localparam logic [7:0] STIF_MODE_CFG_ADDR   = 8'hb4;
	localparam logic [7:0] STIF_PERSIST_ADDR    = 8'hbd;
	localparam logic [7:0] STIF_STATUS_ADDR     = 8'hc0;
	localparam int         STIF_LIGHT_DIRECT_BIT = 7;
	localparam int         STIF_PROX_HYST_BIT    = 6;
	localparam int         STIF_PERSIST_LSB      = 4;
	localparam logic [7:0] STIF_MODE_CFG_RST    = 8'h40;
	localparam logic [7:0] STIF_PERSIST_RST     = 8'h00;
	localparam logic [2:0] STIF_SEL_DEFAULT     = 3'h0;
	localparam logic [2:0] STIF_SEL_LIGHT       = 3'h2;
	localparam logic [2:0] STIF_SEL_PROX_FIRST  = 3'h3;
	localparam logic [2:0] STIF_SEL_PROX_SECOND = 3'h4;
	localparam int         STIF_DATA_W          = 16;

	typedef struct packed {
		logic [STIF_DATA_W-1:0] result;
		logic [STIF_DATA_W-1:0] low_threshold;
		logic [STIF_DATA_W-1:0] high_threshold;
	} stif_meas_t;

	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} stif_reg_req_t;

	typedef enum logic [1:0] {
		STIF_HS_ARMED   = 2'b00,
		STIF_HS_INSIDE  = 2'b01,
		STIF_HS_ABOVE   = 2'b10,
		STIF_HS_BELOW   = 2'b11
	} stif_hyst_state_t;
endpackage

// ===== rtl/stif_prox_channel.sv
// Purpose: One proximity interrupt channel with persistence and hysteresis.
// Assumes: done marks one completed proximity measurement, one cycle wide.
// Notes:   Two copies run side by side, one per proximity result.
`timescale 1ns/1ns
module stif_prox_channel (
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	// Control
	input  wire logic                 prox_sense_enable,
	input  wire logic                 prox_irq_hysteresis_mode,
	input  wire logic [3:0]           prox_persist_count,
	// Measurement
	input  wire logic                 done,
	input  wire stif_pkg::stif_meas_t meas,
	// Result
	output logic                      irq_pulse
);
	import stif_pkg::*;

	logic             out_range;
	logic             above;
	logic             below;
	logic [3:0]       count_q;
	logic [3:0]       count_d;
	logic             persist_ok;
	stif_hyst_state_t state_q;
	logic             hyst_fire;

	assign above      = meas.result > meas.high_threshold;
	assign below      = meas.result < meas.low_threshold;
	assign out_range  = above | below;
	// Saturate instead of wrapping so a long excursion keeps firing.
	assign count_d    = (count_q == 4'hf) ? count_q : count_q + 4'h1;
	assign persist_ok = (prox_persist_count == 4'h0) ||
	                    (out_range && count_d >= prox_persist_count);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			count_q <= 4'h0;
		end else if (done) begin
			if (!out_range) begin
				count_q <= 4'h0;
			end else begin
				count_q <= count_d;
			end
		end
	end

	// Hysteresis: armed until first out-of-range, then only edge crossings fire.
	always_comb begin
		hyst_fire = 1'b0;
		unique case (state_q)
			STIF_HS_ARMED:  hyst_fire = out_range;
			STIF_HS_INSIDE: hyst_fire = out_range;
			STIF_HS_ABOVE:  hyst_fire = below;
			STIF_HS_BELOW:  hyst_fire = above;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q <= STIF_HS_ARMED;
		end else if (!prox_sense_enable) begin
			state_q <= STIF_HS_ARMED;
		end else if (done && persist_ok) begin
			if (above) begin
				state_q <= STIF_HS_ABOVE;
			end else if (below) begin
				state_q <= STIF_HS_BELOW;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			irq_pulse <= 1'b0;
		end else begin
			irq_pulse <= prox_sense_enable && done && persist_ok &&
			             (!prox_irq_hysteresis_mode || hyst_fire);
		end
	end

	zero_count_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(done && !out_range) |=> (count_q == 4'h0))
		else $error("Persistence count not cleared by in-range result.");
	every_cycle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(done && prox_sense_enable && !prox_irq_hysteresis_mode && prox_persist_count == 4'h0)
		|=> irq_pulse)
		else $error("Zero persistence did not fire every cycle.");
	persist_block_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(done && prox_persist_count != 4'h0 && count_d < prox_persist_count) |=> !irq_pulse)
		else $error("Interrupt before persistence count was reached.");
	hyst_quiet_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(done && prox_irq_hysteresis_mode && state_q == STIF_HS_ABOVE && !below) |=> !irq_pulse)
		else $error("Hysteresis fired without a release crossing.");
	first_fire_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(done && prox_sense_enable && prox_irq_hysteresis_mode && prox_persist_count == 4'h0 &&
		 state_q == STIF_HS_ARMED && out_range) |=> irq_pulse)
		else $error("Hysteresis mode missed the first out-of-range interrupt.");
	detect_fire_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(done && prox_sense_enable && prox_irq_hysteresis_mode && prox_persist_count == 4'h0 &&
		 state_q == STIF_HS_BELOW && above) |=> irq_pulse)
		else $error("Hysteresis mode missed a detect crossing.");
endmodule

// ===== rtl/stif_top.sv
// Purpose: Threshold interrupt filter for the light and two proximity channels.
// Assumes: Result strobes come from conversion engines; register port is byte wide.
// Notes:   Pin outputs are active-high levels; pin inversion lives elsewhere.
// How it works
// - Config bit 7 selects direct mode for the light interrupt.
// - Direct light mode fires only when the result crosses a threshold edge.
// - Otherwise light interrupt fires whenever result is above high or below low.
// - In direct mode the live light state drives whichever pin is mapped.
// - Proximity hysteresis with sensing enabled gives one initial out-of-range interrupt.
// - Afterwards a rise from below to above high raises a detect interrupt.
// - Afterwards a fall from above to below low raises a release interrupt.
// - Hysteresis applies to both proximity channels, each with own data and thresholds.
// - Persistence zero with hysteresis off raises a proximity interrupt every proximity cycle.
// - Persistence 1 to 15 needs that many consecutive out-of-range results.
// - An in-range proximity result clears the persistence counter.
`timescale 1ns/1ns
module stif_top (
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    rstn,
	// Register port
	input  wire stif_pkg::stif_reg_req_t reg_req,
	output logic [7:0]                   reg_rdata,
	// Static controls
	input  wire logic                    prox_sense_enable,
	input  wire logic [2:0]              irq_pin_source_select,
	input  wire logic [2:0]              aux_pin_source_select,
	// Light measurement
	input  wire logic                    light_done,
	input  wire stif_pkg::stif_meas_t    light_meas,
	// Proximity measurements
	input  wire logic                    prox_done,
	input  wire stif_pkg::stif_meas_t    prox_meas_first,
	input  wire stif_pkg::stif_meas_t    prox_meas_second,
	// Interrupt outputs
	output logic                         light_irq,
	output logic                         prox_irq_first,
	output logic                         prox_irq_second,
	output logic                         irq_pin,
	output logic                         aux_pin
);
	import stif_pkg::*;

	logic [7:0] mode_cfg_q;
	logic [7:0] persist_q;
	logic [2:0] status_q;
	logic       light_out_q;
	logic       light_out;
	logic       light_fire;
	logic       first_pulse;
	logic       second_pulse;
	logic       light_direct;
	logic       clear_hit;
	logic [1:0] chan_pulse;

	// Pin mapping is needed for both the main and auxiliary pins.
	function automatic logic pin_value(input logic [2:0] sel, input logic li, input logic p0,
	                                   input logic p1, input logic dflt);
		unique case (sel)
			STIF_SEL_LIGHT:       pin_value = li;
			STIF_SEL_PROX_FIRST:  pin_value = p0;
			STIF_SEL_PROX_SECOND: pin_value = p1;
			default:              pin_value = dflt;
		endcase
	endfunction

	assign light_direct = mode_cfg_q[STIF_LIGHT_DIRECT_BIT];
	assign light_out    = (light_meas.result > light_meas.high_threshold) ||
	                      (light_meas.result < light_meas.low_threshold);
	assign light_fire   = light_direct ? (light_out != light_out_q) : light_out;
	assign clear_hit    = reg_req.wr_en && reg_req.addr == STIF_STATUS_ADDR;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mode_cfg_q <= STIF_MODE_CFG_RST;
			persist_q  <= STIF_PERSIST_RST;
		end else if (reg_req.wr_en) begin
			if (reg_req.addr == STIF_MODE_CFG_ADDR) begin
				mode_cfg_q <= {reg_req.wdata[7:6], 6'h00};
			end
			if (reg_req.addr == STIF_PERSIST_ADDR) begin
				persist_q <= reg_req.wdata;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_req.rd_en) begin
			unique case (reg_req.addr)
				STIF_MODE_CFG_ADDR: reg_rdata <= mode_cfg_q;
				STIF_PERSIST_ADDR:  reg_rdata <= persist_q;
				STIF_STATUS_ADDR:   reg_rdata <= {5'h00, status_q};
				default:            reg_rdata <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			light_out_q <= 1'b0;
		end else if (light_done) begin
			light_out_q <= light_out;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			light_irq <= 1'b0;
		end else if (light_direct) begin
			light_irq <= light_done ? light_out : light_out_q;
		end else begin
			light_irq <= light_done && light_fire;
		end
	end

	genvar ch;
	for (ch = 0; ch < 2; ch++) begin : g_prox
		stif_prox_channel u_chan (
			.clk_sys                  (clk_sys),
			.rstn                     (rstn),
			.prox_sense_enable        (prox_sense_enable),
			.prox_irq_hysteresis_mode (mode_cfg_q[STIF_PROX_HYST_BIT]),
			.prox_persist_count       (persist_q[STIF_PERSIST_LSB +: 4]),
			.done                     (prox_done),
			.meas                     (ch == 0 ? prox_meas_first : prox_meas_second),
			.irq_pulse                (chan_pulse[ch])
		);
	end

	assign first_pulse  = chan_pulse[0];
	assign second_pulse = chan_pulse[1];

	// Sticky status: a new event in the clearing cycle wins over the clear.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			status_q <= 3'h0;
		end else begin
			status_q <= (status_q & ~(clear_hit ? reg_req.wdata[2:0] : 3'h0)) |
			            {second_pulse, first_pulse, light_done && light_fire};
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			prox_irq_first  <= 1'b0;
			prox_irq_second <= 1'b0;
			irq_pin         <= 1'b0;
			aux_pin         <= 1'b0;
		end else begin
			prox_irq_first  <= status_q[1];
			prox_irq_second <= status_q[2];
			irq_pin <= pin_value(irq_pin_source_select,
			                     light_direct ? light_irq : status_q[0],
			                     status_q[1], status_q[2], |status_q);
			aux_pin <= pin_value(aux_pin_source_select,
			                     light_direct ? light_irq : status_q[0],
			                     status_q[1], status_q[2], 1'b0);
		end
	end

	sequence light_cross_s;
		light_direct && light_done && (light_out != light_out_q);
	endsequence

	sequence pin_light_s;
		light_direct && irq_pin_source_select == STIF_SEL_LIGHT;
	endsequence

	sequence aux_light_s;
		light_direct && aux_pin_source_select == STIF_SEL_LIGHT;
	endsequence

	sequence cfg_write_s;
		reg_req.wr_en && reg_req.addr == STIF_MODE_CFG_ADDR;
	endsequence

	sequence persist_write_s;
		reg_req.wr_en && reg_req.addr == STIF_PERSIST_ADDR;
	endsequence

	direct_edge_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(light_direct && light_done && light_out == light_out_q) |=> !status_q[0] || $past(status_q[0]))
		else $error("Direct light mode fired without a threshold crossing.");
	direct_cross_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		light_cross_s |=> status_q[0])
		else $error("Direct light crossing did not set status.");
	level_light_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(!light_direct && light_done && light_out) |=> light_irq)
		else $error("Level light mode missed out-of-range result.");
	level_quiet_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(!light_direct && light_done && !light_out) |=> !light_irq)
		else $error("Level light mode fired on an in-range result.");
	level_pin_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(!light_direct && irq_pin_source_select == STIF_SEL_LIGHT && status_q[0]) |=> irq_pin)
		else $error("Pending light event not shown on the mapped pin.");
	direct_live_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(light_direct && light_done) |=> light_irq == $past(light_out))
		else $error("Light interrupt does not follow the live result.");
	direct_pin_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		pin_light_s ##1 pin_light_s |=> irq_pin == $past(light_irq))
		else $error("Mapped pin does not follow live light state.");
	direct_aux_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		aux_light_s ##1 aux_light_s |=> aux_pin == $past(light_irq))
		else $error("Auxiliary pin does not follow live light state.");
	cfg_bit_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		cfg_write_s |=> light_direct == $past(reg_req.wdata[STIF_LIGHT_DIRECT_BIT]))
		else $error("Direct mode bit not written.");
	hyst_bit_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		cfg_write_s |=> mode_cfg_q[STIF_PROX_HYST_BIT] == $past(reg_req.wdata[STIF_PROX_HYST_BIT]))
		else $error("Proximity hysteresis bit not written.");
	persist_bit_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		persist_write_s |=> persist_q == $past(reg_req.wdata))
		else $error("Persistence setting not written.");
	// A clear in the same cycle must never swallow a fresh proximity event.
	first_status_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		first_pulse |=> status_q[1])
		else $error("First proximity event lost from status.");
	second_status_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		second_pulse |=> status_q[2])
		else $error("Second proximity event lost from status.");
	first_pin_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		status_q[1] |=> prox_irq_first)
		else $error("First proximity output does not show pending event.");
endmodule

// ===== tb/sensor_threshold_interrupt_filter_tb.sv
// Purpose: Self-checking bench for the threshold interrupt filter.
// Assumes: Low threshold 100 and high 200, except 300 and 400 on the second proximity channel.
// Notes:   Status is read and cleared after every measurement, so each check sees only that measurement's events.
`timescale 1ns/1ns
module sensor_threshold_interrupt_filter_tb;
	import stif_pkg::*;
	logic          clk_sys, rstn, prox_sense_enable, light_done, prox_done;
	logic [2:0]    irq_pin_source_select, aux_pin_source_select;
	stif_reg_req_t reg_req;
	logic [7:0]    reg_rdata, s;
	stif_meas_t    light_meas, prox_meas_first, prox_meas_second;
	logic          light_irq, prox_irq_first, prox_irq_second, irq_pin, aux_pin;
	int            fails, total_checks, n;
	stif_top dut (.clk_sys(clk_sys), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.prox_sense_enable(prox_sense_enable), .irq_pin_source_select(irq_pin_source_select),
		.aux_pin_source_select(aux_pin_source_select), .light_done(light_done), .light_meas(light_meas),
		.prox_done(prox_done), .prox_meas_first(prox_meas_first), .prox_meas_second(prox_meas_second),
		.light_irq(light_irq), .prox_irq_first(prox_irq_first), .prox_irq_second(prox_irq_second),
		.irq_pin(irq_pin), .aux_pin(aux_pin));
	stif_host_model host (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Kind 0 is inside the range, 1 above the high threshold, 2 below the low one.
	function automatic logic [15:0] pick(input int k, input logic [15:0] lo);
		case (k)
			0: pick = lo + 16'($urandom % 101);
			1: pick = lo + 16'd101 + 16'($urandom % 1000);
			default: pick = 16'($urandom % lo);
		endcase
	endfunction
	function automatic logic [15:0] exp_fire(input int cnt, input int p);
		exp_fire = (p == 0 || cnt >= p) ? 16'h0006 : 16'h0000;
	endfunction
	task automatic prox(input int k1, input int k2);
		@(negedge clk_sys);
		prox_meas_first = '{pick(k1, 16'd100), 16'd100, 16'd200};
		prox_meas_second = '{pick(k2, 16'd300), 16'd300, 16'd400};
		prox_done = 1'b1;
		@(negedge clk_sys);
		prox_done = 1'b0;
		repeat (4) @(negedge clk_sys);
	endtask
	task automatic light(input int k);
		@(negedge clk_sys);
		light_meas = '{pick(k, 16'd100), 16'd100, 16'd200};
		light_done = 1'b1;
		@(negedge clk_sys);
		light_done = 1'b0;
		repeat (4) @(negedge clk_sys);
	endtask
	// Pins are looked at before the read, since clearing status drops them.
	task automatic expect_st(input logic [15:0] exp);
		check(16'({prox_irq_second, prox_irq_first, 1'b0}), exp & 16'h0006);
		check(16'(aux_pin), 16'(exp[1]));
		if (irq_pin_source_select == STIF_SEL_DEFAULT)
			check(16'(irq_pin), 16'(exp != 16'h0000));
		host.rd(STIF_STATUS_ADDR, s);
		check(16'(s), exp);
		host.wr(STIF_STATUS_ADDR, 8'h07);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		#(40 * 60000);
		fails++;
		end_sim();
	end
	initial begin
		{rstn, light_done, prox_done, light_meas, prox_meas_first, prox_meas_second} = '0;
		prox_sense_enable = 1'b1;
		irq_pin_source_select = STIF_SEL_LIGHT;
		aux_pin_source_select = STIF_SEL_PROX_FIRST;
		void'($urandom(32'hca184066));
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys) rstn = 1'b1;
		host.rd(STIF_MODE_CFG_ADDR, s);
		check(16'(s), 16'(STIF_MODE_CFG_RST));
		host.rd(STIF_PERSIST_ADDR, s);
		check(16'(s), 16'(STIF_PERSIST_RST));
		host.rd(8'h10, s);
		check(16'(s), 16'h0000);
		host.wr(STIF_MODE_CFG_ADDR, 8'hff);
		host.rd(STIF_MODE_CFG_ADDR, s);
		check(16'(s), 16'h00c0);
		$display("test registers done");
		@(negedge clk_sys) irq_pin_source_select = STIF_SEL_DEFAULT;
		host.wr(STIF_MODE_CFG_ADDR, 8'h00);
		for (int t = 0; t < 4; t++) begin
			n = (t == 0) ? 0 : (t == 1) ? 15 : 1 + int'($urandom % 14);
			host.wr(STIF_PERSIST_ADDR, 8'(n << STIF_PERSIST_LSB));
			prox(0, 0);
			expect_st(exp_fire(0, n));
			for (int i = 1; i <= n + 1; i++) begin
				prox(1, 2);
				expect_st(exp_fire(i, n));
			end
			prox(0, 0);
			expect_st(exp_fire(0, n));
			prox(2, 1);
			expect_st(exp_fire(1, n));
		end
		$display("test persistence done");
		host.wr(STIF_PERSIST_ADDR, 8'h00);
		host.wr(STIF_MODE_CFG_ADDR, 8'h40);
		@(negedge clk_sys) prox_sense_enable = 1'b0;
		prox(1, 2);
		expect_st(16'h0000);
		@(negedge clk_sys) prox_sense_enable = 1'b1;
		prox(0, 0);
		expect_st(16'h0000);
		prox(1, 2);
		expect_st(16'h0006);
		prox(1, 2);
		expect_st(16'h0000);
		prox(2, 2);
		expect_st(16'h0002);
		prox(0, 1);
		expect_st(16'h0004);
		prox(1, 1);
		expect_st(16'h0002);
		$display("test hysteresis done");
		@(negedge clk_sys) irq_pin_source_select = STIF_SEL_LIGHT;
		host.wr(STIF_MODE_CFG_ADDR, 8'h00);
		light(1);
		check(16'(light_irq), 16'h0000);
		expect_st(16'h0001);
		light(2);
		expect_st(16'h0001);
		light(0);
		expect_st(16'h0000);
		host.wr(STIF_MODE_CFG_ADDR, 8'h80);
		light(1);
		check(16'(irq_pin), 16'h0001);
		check(16'(light_irq), 16'h0001);
		expect_st(16'h0001);
		light(1);
		expect_st(16'h0000);
		light(0);
		check(16'(irq_pin), 16'h0000);
		check(16'(light_irq), 16'h0000);
		expect_st(16'h0001);
		$display("test light done");
		end_sim();
	end
endmodule

// ===== tb/stif_host_model.sv
// Purpose: Host model that reaches the filter's registers over the byte-wide register port.
// Assumes: Requests change at the falling edge and stand over exactly one rising edge.
// Notes:   Read data is taken at the next falling edge, once the registered answer has settled.
`timescale 1ns/1ns
module stif_host_model (
	// Clock
	input  wire logic               clk_sys,
	// Register port
	output stif_pkg::stif_reg_req_t reg_req,
	input  wire logic [7:0]         reg_rdata
);
	import stif_pkg::*;
	initial reg_req = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
		@(negedge clk_sys);
		reg_req = '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk_sys);
		reg_req = '0;
		d = reg_rdata;
	endtask
endmodule
